// file: hw/phy_special_regs.sv
/*
 * management-link slave for the special-mode, special-control, interrupt
 * source and interrupt mask registers, with the decode they steer.
 * assumes the management clock and data pins are asynchronous and much
 * slower than the core clock; event inputs come from core-clock logic.
 */
module phy_special_regs
    import phy_regs_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    input  wire logic                   mdc,
    input  wire logic                   mdio_i,
    output logic                        mdio_o,
    output logic                        mdio_oe,
    input  wire logic                   crossover_auto_strap_pin,
    input  wire logic                   soft_reset,
    input  wire logic [7:0]             int_events,
    input  wire logic                   rx_polarity_reversed,
    input  wire logic                   tx_active,
    input  wire logic                   rx_active,
    output phy_regs_pkg::mode_cfg_t     mode_cfg_q,
    output logic                        carrier_sense_q,
    output logic                        crossover_auto_en_q,
    output logic                        pairs_swapped_q,
    output logic                        rx_pll_reference_lock_q,
    output logic [7:0]                  irq_sources_q
);
    import phy_regs_pkg::*;

    // -------------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------------
    logic mdc_s1, mdc_s2, mdc_s3;  // s3 only delays s2 for edge finding
    logic mdio_s1, mdio_s;
    logic strap_s1, strap_s;

    // two flops per pin, three on mdc; nothing reads a first stage except its second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {mdc_s1, mdc_s2, mdc_s3} <= 3'h0;
            {mdio_s1, mdio_s}        <= 2'h3;
            {strap_s1, strap_s}      <= 2'h0;
        end else begin
            {mdc_s1, mdc_s2, mdc_s3} <= {mdc, mdc_s1, mdc_s2};
            {mdio_s1, mdio_s}        <= {mdio_i, mdio_s1};
            {strap_s1, strap_s}      <= {crossover_auto_strap_pin, strap_s1};
        end
    end

    wire logic mdc_rise = mdc_s2 & ~mdc_s3; // one core cycle per link bit

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} frame_st_t;

    frame_st_t   state_q, state_d;
    logic [5:0]  cnt_q, cnt_d;          // preamble / header / data bit count
    logic [12:0] hdr_q, hdr_d;          // header bits collected so far
    logic [15:0] data_q, data_d;        // data shift register
    logic        wr_q, wr_d;            // frame is a write
    logic [4:0]  reg_q, reg_d;          // register index of this frame
    logic        mdio_o_q, mdio_o_d;
    logic        mdio_oe_q, mdio_oe_d;
    logic [2:0]  mode_q, mode_d;        // operating mode
    logic [4:0]  addr_q, addr_d;        // management address
    logic        xo_ovr_q, xo_ovr_d;    // strap override
    logic        xo_auto_q, xo_auto_d;  // automatic crossover under override
    logic        xo_state_q, xo_state_d; // manual pair orientation
    logic        pll_lock_q, pll_lock_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  mask_q, mask_d;
    mode_cfg_t   cfg_d;
    logic        crs_d, xo_auto_en_d, swapped_d;
    logic [7:0]  irq_d;

    // read view of the control register, low nibble fixed
    logic [15:0] ctrl_rd;
    assign ctrl_rd = {xo_ovr_q, xo_auto_q, xo_state_q, 2'h0, pll_lock_q,
                      5'h00, rx_polarity_reversed, CTRL_ID_BITS}; // R17 R18

    // -------------------------------------------------------------------
    // frame engine, register writes and decode
    // -------------------------------------------------------------------
    always_comb begin
        logic [13:0] hw;   // complete header word
        logic [15:0] dw;   // complete write word
        logic [15:0] rv;   // value returned on a read
        logic [7:0]  clr;  // flags being read out, or all on soft reset, this cycle
        hw = {hdr_q, mdio_s};
        dw = {data_q[14:0], mdio_s};
        clr = 8'h00;
        case (reg_q)
            IDX_SPECIAL_MODES: rv = {8'h00, mode_q, addr_q};
            IDX_SPECIAL_CTRL:  rv = ctrl_rd;
            IDX_INT_SOURCE:    rv = {8'h00, flags_q};
            default:           rv = {8'h00, mask_q};
        endcase
        state_d    = state_q;
        cnt_d      = cnt_q;
        hdr_d      = hdr_q;
        data_d     = data_q;
        wr_d       = wr_q;
        reg_d      = reg_q;
        mdio_o_d   = mdio_o_q;
        mdio_oe_d  = mdio_oe_q;
        mode_d     = mode_q;
        addr_d     = addr_q;
        xo_ovr_d   = xo_ovr_q;
        xo_auto_d  = xo_auto_q;
        xo_state_d = xo_state_q;
        pll_lock_d = pll_lock_q;
        mask_d     = mask_q;
        if (mdc_rise) begin
            case (state_q)
                // count ones; a zero after a full preamble opens a frame
                ST_PRE: begin
                    if (mdio_s) begin
                        cnt_d = (cnt_q == PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
                    end else if (cnt_q == PREAMBLE_LEN) begin
                        state_d = ST_HDR;
                        hdr_d   = 13'h0000;
                        cnt_d   = 6'h01;
                    end else begin
                        cnt_d = 6'h00;
                    end
                end
                // collect start, op, address and index, then decide
                ST_HDR: begin
                    hdr_d = hw[12:0];
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == HDR_LAST) begin
                        cnt_d   = 6'h00;
                        state_d = ST_PRE;
                        wr_d    = (hw[11:10] == OP_WRITE);
                        reg_d   = hw[4:0];
                        if (hw[13:12] == START_CODE && hw[9:5] == addr_q // R2
                            && (hw[11:10] == OP_READ || hw[11:10] == OP_WRITE)
                            && (hw[4:0] == IDX_SPECIAL_MODES
                                || hw[4:0] == IDX_SPECIAL_CTRL
                                || hw[4:0] == IDX_INT_SOURCE
                                || hw[4:0] == IDX_INT_MASK)) begin
                            state_d = ST_TA;
                        end
                    end
                end
                // turnaround: on a read take the line and drive zero
                ST_TA: begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == 6'h00) begin
                        mdio_oe_d = ~wr_q;
                        mdio_o_d  = 1'b0;
                    end else begin
                        state_d = ST_DATA;
                        cnt_d   = 6'h00;
                        if (!wr_q) begin
                            mdio_o_d = rv[15];
                            data_d   = {rv[14:0], 1'b0};
                            // reading the flag register releases its flags
                            if (reg_q == IDX_INT_SOURCE) begin
                                clr = flags_q; // R22
                            end
                        end
                    end
                end
                // sixteen data bits in or out
                ST_DATA: begin
                    cnt_d = cnt_q + 6'h01;
                    if (wr_q) begin
                        data_d = dw;
                    end else begin
                        mdio_o_d = data_q[15];
                        data_d   = {data_q[14:0], 1'b0};
                    end
                    if (cnt_q == DATA_LAST) begin
                        state_d   = ST_PRE;
                        cnt_d     = 6'h00;
                        mdio_oe_d = 1'b0;
                        mdio_o_d  = 1'b0;
                        if (wr_q) begin
                            case (reg_q)
                                IDX_SPECIAL_MODES: begin
                                    mode_d = dw[MODE_LSB +: 3]; // R1
                                    addr_d = dw[ADDR_LSB +: 5]; // R2
                                end
                                IDX_SPECIAL_CTRL: begin
                                    // low nibble and polarity are not stored
                                    xo_ovr_d   = dw[XO_OVR_BIT];   // R11
                                    xo_auto_d  = dw[XO_AUTO_BIT];  // R12
                                    xo_state_d = dw[XO_STATE_BIT]; // R13
                                    pll_lock_d = dw[PLL_BIT];      // R16
                                end
                                IDX_INT_MASK: begin
                                    mask_d = dw[7:0]; // R21
                                end
                                default: begin
                                    // flag register ignores writes
                                end
                            endcase
                        end
                    end
                end
                default: begin
                    state_d = ST_PRE;
                    cnt_d   = 6'h00;
                end
            endcase
        end
        // soft reset clears all but the fields meant to survive it
        if (soft_reset) begin
            xo_ovr_d   = 1'b0; // R23
            xo_auto_d  = 1'b0;
            xo_state_d = 1'b0;
            mask_d     = MASK_RESET;
            clr        = 8'hFF;
        end
        // an event in the clearing cycle wins; bit 0 never sets
        flags_d = (flags_q & ~clr) | {int_events[7:1], 1'b0}; // R19 R20 R22
        cfg_d   = decode_mode(mode_q); // R3 R4 R5 R6 R7 R8 R10
        // carrier follows transmit only in modes that ask for it
        crs_d = rx_active | (cfg_d.crs_on_tx & tx_active); // R5 R6 R7 R8
        // strap decides unless the override is set
        xo_auto_en_d = xo_ovr_q ? xo_auto_q : strap_s; // R11 R12
        swapped_d    = xo_ovr_q & ~xo_auto_q & xo_state_q; // R13
        irq_d        = flags_q & mask_q; // R21
    end

    // register everything computed above
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q                 <= ST_PRE;
            cnt_q                   <= 6'h00;
            hdr_q                   <= 13'h0000;
            data_q                  <= 16'h0000;
            wr_q                    <= 1'b0;
            reg_q                   <= 5'h00;
            mdio_o_q                <= 1'b0;
            mdio_oe_q               <= 1'b0;
            mode_q                  <= MODE_RESET;
            addr_q                  <= ADDR_RESET;
            xo_ovr_q                <= 1'b0;
            xo_auto_q               <= 1'b0;
            xo_state_q              <= 1'b0;
            pll_lock_q              <= 1'b0;
            flags_q                 <= FLAGS_RESET;
            mask_q                  <= MASK_RESET;
            mode_cfg_q              <= '0;
            carrier_sense_q         <= 1'b0;
            crossover_auto_en_q     <= 1'b0;
            pairs_swapped_q         <= 1'b0;
            irq_sources_q           <= 8'h00;
        end else begin
            state_q                 <= state_d;
            cnt_q                   <= cnt_d;
            hdr_q                   <= hdr_d;
            data_q                  <= data_d;
            wr_q                    <= wr_d;
            reg_q                   <= reg_d;
            mdio_o_q                <= mdio_o_d;
            mdio_oe_q               <= mdio_oe_d;
            mode_q                  <= mode_d;
            addr_q                  <= addr_d;
            xo_ovr_q                <= xo_ovr_d;
            xo_auto_q               <= xo_auto_d;
            xo_state_q              <= xo_state_d;
            pll_lock_q              <= pll_lock_d;
            flags_q                 <= flags_d;
            mask_q                  <= mask_d;
            mode_cfg_q              <= cfg_d;
            carrier_sense_q         <= crs_d;
            crossover_auto_en_q     <= xo_auto_en_d;
            pairs_swapped_q         <= swapped_d;
            irq_sources_q           <= irq_d;
        end
    end

    assign mdio_o                  = mdio_o_q;
    assign mdio_oe                 = mdio_oe_q;
    assign rx_pll_reference_lock_q = pll_lock_q; // R16

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence turn_drive_s;
        $rose(mdio_oe_q) && !mdio_o_q;
    endsequence
    sequence drive_held_s;
        mdio_oe_q [*8];
    endsequence

    flag_latch_a: assert property (int_events[6] |=> flags_q[6]) // R22
        else $error("event did not latch its flag");
    flag_zero_a: assert property (flags_q[0] == 1'b0 && irq_sources_q[0] == 1'b0) // R20
        else $error("flag bit zero set");
    ctrl_nibble_a: assert property (ctrl_rd[3:0] == 4'hB) // R18
        else $error("control low nibble not 1011");
    mode_10hd_a: assert property (mode_q == MODE_10_HD |=> // R3
        mode_cfg_q.ctrl_defaults == 4'h0 && !mode_cfg_q.autoneg_en)
        else $error("mode 000 decode wrong");
    crs_full_a: assert property (mode_q == MODE_100_FD && !rx_active // R6
        |=> !carrier_sense_q)
        else $error("carrier raised on transmit in full duplex");
    manual_xo_a: assert property (xo_ovr_q && !xo_auto_q // R13
        |=> pairs_swapped_q == $past(xo_state_q))
        else $error("manual crossover not applied");
    strap_xo_a: assert property (!xo_ovr_q // R11
        |=> crossover_auto_en_q == $past(strap_s))
        else $error("strap not followed");
    read_drive_a: assert property (turn_drive_s |-> drive_held_s) // R2
        else $error("read answer dropped early");
    soft_keep_a: assert property (soft_reset && !mdc_rise // R23
        |=> mode_q == $past(mode_q) && pll_lock_q == $past(pll_lock_q))
        else $error("kept field lost on soft reset");
    mask_gate_a: assert property (!mask_q[7] |=> !irq_sources_q[7]) // R21
        else $error("masked source passed");

endmodule : phy_special_regs

// file: hw/phy_regs_pkg.sv
/*
 * constants, field layout, reset values and mode decode for the transceiver's
 * special-mode, special-control and interrupt-source registers.
 * assumes one 250 MHz core clock and a management link clocked well below it.
 */
// Operation
// [R1] operating mode field bits 7:5, read/write
// [R2] address field 4:0, default 00001b, answer it
// [R3] mode 000: 10M half, no autoneg
// [R4] mode 001: 10M full, no autoneg
// [R5] mode 010: 100M half, carrier on tx+rx
// [R6] mode 011: 100M full, carrier rx only
// [R7] mode 100: autoneg, advertise 100M half only
// [R8] mode 101: repeater, autoneg, carrier rx only
// [R9] station never programs mode 110
// [R10] mode 111: autoneg, advertise everything
// [R11] override clear: strap pin controls crossover
// [R12] auto bit counts only under override
// [R13] manual state bit swaps pair directions
// [R14] station writes state 0 when auto
// [R15] station never sets all three bits
// [R16] pll bit holds receive pll on reference
// [R17] polarity bit reports reversed receive polarity
// [R18] bits 3:0 read 1011b, writes ignored
// [R19] flags 7..4: energy, autoneg, fault, linkdown
// [R20] flags 3..1: ack, parallel fault, page; bit0 zero
// [R21] mask bits enable sources, all masked at reset
// [R22] flags latch until read, event re-sets them
// [R23] mode, address, pll lock survive soft reset
package phy_regs_pkg;

    // -------------------------------------------------------------------
    // register indices on the management link
    // -------------------------------------------------------------------
    localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_CTRL  = 5'h1B;
    localparam logic [4:0] IDX_INT_SOURCE    = 5'h1D;
    localparam logic [4:0] IDX_INT_MASK      = 5'h1E;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int unsigned MODE_LSB     = 5;
    localparam int unsigned ADDR_LSB     = 0;
    localparam int unsigned XO_OVR_BIT   = 15;
    localparam int unsigned XO_AUTO_BIT  = 14;
    localparam int unsigned XO_STATE_BIT = 13;
    localparam int unsigned PLL_BIT      = 10;
    localparam int unsigned POL_BIT      = 4;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [2:0]  MODE_RESET   = 3'h7;
    localparam logic [4:0]  ADDR_RESET   = 5'h01;
    localparam logic [3:0]  CTRL_ID_BITS = 4'hB;
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [7:0]  MASK_RESET   = 8'h00;

    // -------------------------------------------------------------------
    // management frame layout
    // -------------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_LEN = 6'h20; // 32 ones before a start
    localparam logic [5:0] HDR_LAST     = 6'h0D; // start+op+phy+reg = 14 bits
    localparam logic [5:0] DATA_LAST    = 6'h0F; // 16 data bits
    localparam logic [1:0] START_CODE   = 2'h1;
    localparam logic [1:0] OP_READ      = 2'h2;
    localparam logic [1:0] OP_WRITE     = 2'h1;

    // -------------------------------------------------------------------
    // operating mode codes
    // -------------------------------------------------------------------
    localparam logic [2:0] MODE_10_HD   = 3'h0;
    localparam logic [2:0] MODE_10_FD   = 3'h1;
    localparam logic [2:0] MODE_100_HD  = 3'h2;
    localparam logic [2:0] MODE_100_FD  = 3'h3;
    localparam logic [2:0] MODE_AN_100H = 3'h4;
    localparam logic [2:0] MODE_REPEAT  = 3'h5;
    localparam logic [2:0] MODE_ALL     = 3'h7;

    // decoded view of one mode
    typedef struct packed {
        logic       speed_100;
        logic       full_duplex;
        logic       autoneg_en;
        logic       repeater;
        logic       crs_on_tx;
        logic [3:0] ctrl_defaults; // basic control bits 13,12,10,8
        logic [3:0] adv_defaults;  // advertisement bits 8,7,6,5
    } mode_cfg_t;

    // mode code to behaviour; reserved code falls back to 10M half
    function automatic mode_cfg_t decode_mode(input logic [2:0] mode);
        mode_cfg_t c;
        c = '0;
        case (mode)
            MODE_10_FD: begin
                c.full_duplex   = 1'b1;
                c.ctrl_defaults = 4'h1;
            end
            MODE_100_HD: begin
                c.speed_100     = 1'b1;
                c.crs_on_tx     = 1'b1;
                c.ctrl_defaults = 4'h8;
            end
            MODE_100_FD: begin
                c.speed_100     = 1'b1;
                c.full_duplex   = 1'b1;
                c.ctrl_defaults = 4'h9;
            end
            MODE_AN_100H, MODE_REPEAT: begin
                c.speed_100     = 1'b1;
                c.autoneg_en    = 1'b1;
                c.repeater      = (mode == MODE_REPEAT);
                c.crs_on_tx     = (mode == MODE_AN_100H);
                c.ctrl_defaults = 4'hC;
                c.adv_defaults  = 4'h4;
            end
            MODE_ALL: begin
                c.speed_100     = 1'b1;
                c.full_duplex   = 1'b1;
                c.autoneg_en    = 1'b1;
                c.crs_on_tx     = 1'b1;
                c.ctrl_defaults = 4'hD; // don't-care bits resolved to 1
                c.adv_defaults  = 4'hF;
            end
            default: begin
                c.crs_on_tx     = 1'b1; // 10M half duplex
            end
        endcase
        return c;
    endfunction : decode_mode

endpackage : phy_regs_pkg

// file: testbench/mgmt_station.sv
/*
 * management station model: clocks read and write frames on the link.
 * assumes the bench resolves the data wire with a pull-up and a core clock
 * of 4 ns, so one link bit takes 8 core clocks (32 ns).
 */
module mgmt_station (
    input  wire logic clock,
    input  wire logic mdio_line,
    output logic      mdc,
    output logic      st_o,
    output logic      st_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // link clock stands low and the line is released between frames
    initial begin
        mdc   = 1'b0;
        st_o  = 1'b1;
        st_oe = 1'b0;
    end

    // -------------------------------------------------------------------
    // one frame: preamble, start, op, address, index, turnaround, data
    // -------------------------------------------------------------------
    // data changes only while the clock is low, so every rise sees it settled
    task automatic frame(input logic [1:0] op, input logic [4:0] addr,
                         input logic [4:0] idx, input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic [63:0] bits;
        logic        rd;
        bits  = {32'hFFFF_FFFF, 2'b01, op, addr, idx, 2'b10, wdata};
        rd    = (op == 2'b10);
        rdata = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clock);
            #1;
            mdc   = 1'b0;
            st_oe = !(rd && i < 18); // released for turnaround and read data
            st_o  = bits[i];
            repeat (4) @(posedge clock);
            #1;
            if (rd && i < 16) rdata = {rdata[14:0], mdio_line};
            mdc = 1'b1;
            repeat (3) @(posedge clock);
        end
        @(posedge clock);
        #1;
        mdc   = 1'b0;
        st_oe = 1'b0;
        repeat (8) @(posedge clock); // lets a write land before the caller looks
        #1;
    endtask : frame
endmodule : mgmt_station

// file: testbench/testbench.sv
/*
 * self-checking bench for the special register block: drives frames through
 * the station model and compares read data and decoded outputs.
 * assumes the package constants for indices and opcodes.
 */
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import phy_regs_pkg::*;

    logic        clock, arst_n, mdc, mdio_line, mdio_o, mdio_oe, st_o, st_oe;
    logic        strap, soft_reset, pol, tx_active, rx_active;
    logic [7:0]  int_events, irq_q;
    mode_cfg_t   mode_cfg_q;
    logic        carrier_sense_q, auto_en_q, swapped_q, pll_lock_q;
    logic [15:0] rdata;
    int          n_fail, tests_run, cycles;
    // expected decode per mode code; entry 6 is never used
    logic [12:0] exp_cfg [8] = '{13'h0100, 13'h0810, 13'h1180, 13'h1890,
                                 13'h15C4, 13'h16C4, 13'h0100, 13'h1DDF};
    logic [15:0] xo_w [4] = '{16'h0000, 16'h8000, 16'hA000, 16'hC000};
    logic [1:0]  xo_e [4] = '{2'h2, 2'h0, 2'h1, 2'h2};

    // wire with pull-up: device wins, then station, else idle high
    assign mdio_line = mdio_oe ? mdio_o : (st_oe ? st_o : 1'b1);

    mgmt_station ms (.clock(clock), .mdio_line(mdio_line), .mdc(mdc), .st_o(st_o),
        .st_oe(st_oe));
    phy_special_regs uut (.clock(clock), .arst_n(arst_n), .mdc(mdc), .mdio_i(mdio_line),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .crossover_auto_strap_pin(strap),
        .soft_reset(soft_reset), .int_events(int_events), .rx_polarity_reversed(pol),
        .tx_active(tx_active), .rx_active(rx_active), .mode_cfg_q(mode_cfg_q),
        .carrier_sense_q(carrier_sense_q), .crossover_auto_en_q(auto_en_q),
        .pairs_swapped_q(swapped_q), .rx_pll_reference_lock_q(pll_lock_q),
        .irq_sources_q(irq_q));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // -------------------------------------------------------------------
    // access tasks and closing report
    // -------------------------------------------------------------------
    task automatic acc(input logic [1:0] op, input logic [4:0] idx,
                       input logic [15:0] d, input logic [4:0] addr = 5'h01);
        ms.frame(op, addr, idx, d, rdata);
    endtask : acc

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // hang guard: a full run needs about 17000 cycles
    initial begin
        cycles = 0;
        forever begin
            @(posedge clock);
            cycles++;
            if (cycles == 40000) begin
                n_fail++;
                complete_run();
            end
        end
    end

    initial begin
        {arst_n, soft_reset, pol, rx_active, int_events} = '0;
        {strap, tx_active} = 2'b11;
        n_fail = 0;
        tests_run = 0;
        repeat (3) @(posedge clock);
        #1 arst_n = 1'b1;
        step(6);
        acc(OP_READ, IDX_SPECIAL_MODES, 16'h0000);
        `CHK("modes_reset", 16'h00E1, rdata)
        acc(OP_READ, IDX_SPECIAL_CTRL, 16'h0000);
        `CHK("ctrl_reset", 16'h000B, rdata)
        acc(OP_READ, IDX_INT_SOURCE, 16'h0000);
        `CHK("flags_reset", 16'h0000, rdata)
        $display("test reset done");
        for (int m = 0; m < 8; m++) begin
            if (m == 6) continue;
            acc(OP_WRITE, IDX_SPECIAL_MODES, {8'h00, 3'(m), 5'h01});
            acc(OP_READ, IDX_SPECIAL_MODES, 16'h0000);
            `CHK("mode_rw", {8'h00, 3'(m), 5'h01}, rdata)
            `CHK("mode_cfg", exp_cfg[m], mode_cfg_q)
            `CHK("carrier", exp_cfg[m][8], carrier_sense_q)
            // receive alone must raise carrier in every mode
            {tx_active, rx_active} = 2'b01;
            step(2);
            `CHK("carrier_rx", 1'b1, carrier_sense_q)
            {tx_active, rx_active} = 2'b10;
        end
        acc(OP_WRITE, IDX_SPECIAL_MODES, 16'h00E3);
        acc(OP_READ, IDX_SPECIAL_MODES, 16'h0000);
        `CHK("old_addr", 16'hFFFF, rdata)
        acc(OP_READ, IDX_SPECIAL_MODES, 16'h0000, 5'h03);
        `CHK("new_addr", 16'h00E3, rdata)
        acc(OP_WRITE, IDX_SPECIAL_MODES, 16'h00E1, 5'h03);
        $display("test modes done");
        for (int k = 0; k < 4; k++) begin
            acc(OP_WRITE, IDX_SPECIAL_CTRL, xo_w[k]);
            `CHK("crossover", xo_e[k], {auto_en_q, swapped_q})
        end
        {strap, pol} = 2'b01;
        acc(OP_WRITE, IDX_SPECIAL_CTRL, 16'h7C1F);
        `CHK("strap_rules", 2'h0, {auto_en_q, swapped_q})
        `CHK("pll_lock", 1'b1, pll_lock_q)
        acc(OP_READ, IDX_SPECIAL_CTRL, 16'h0000);
        `CHK("ctrl_rw", 16'h641B, rdata)
        $display("test control done");
        int_events = 8'hFF;
        step(1);
        int_events = 8'h00;
        step(2);
        `CHK("irq_masked", 8'h00, irq_q)
        acc(OP_WRITE, IDX_INT_MASK, 16'h00F0);
        `CHK("irq_enabled", 8'hF0, irq_q)
        acc(OP_READ, IDX_INT_SOURCE, 16'h0000);
        `CHK("flags", 16'h00FE, rdata)
        acc(OP_READ, IDX_INT_SOURCE, 16'h0000);
        `CHK("flags_clear", 16'h0000, rdata)
        `CHK("irq_clear", 8'h00, irq_q)
        $display("test flags done");
        int_events = 8'h40;
        step(1);
        {int_events, soft_reset} = 9'h001;
        step(1);
        soft_reset = 1'b0;
        step(2);
        acc(OP_READ, IDX_SPECIAL_MODES, 16'h0000);
        `CHK("kept_mode", 16'h00E1, rdata)
        `CHK("kept_pll", 1'b1, pll_lock_q)
        acc(OP_READ, IDX_SPECIAL_CTRL, 16'h0000);
        `CHK("ctrl_soft", 16'h041B, rdata)
        // the flag latched just before the soft reset must be gone
        acc(OP_READ, IDX_INT_SOURCE, 16'h0000);
        `CHK("flags_soft", 16'h0000, rdata)
        $display("test soft reset done");
        complete_run();
    end
endmodule : testbench
